// file: hdl/mtc_defs.svh
// offsets, field positions, reset values and timing counts of the transmit control block
`ifndef MTC_DEFS_SVH
`define MTC_DEFS_SVH
`define MTC_OFF_CTRL       16'ha008
`define MTC_OFF_STAT       16'ha00c
`define MTC_OFF_EVT        16'ha010
`define MTC_CTRL_RESET     32'h00000000
`define MTC_STAT_RESET     32'h00000000
`define MTC_CTRL_MASK      32'h00007fff
`define MTC_B_TX_ENABLE_BIT         0
`define MTC_B_HALTREQ      1
`define MTC_B_PAD_SUPPRESS        2
`define MTC_B_NOFCS        3
`define MTC_B_FAST_BACKOFF        4
`define MTC_B_DEFER_COUNTER_DISABLE        5
`define MTC_B_SEND_CONTROL_FRAME      6
`define MTC_B_SQE          7
`define MTC_B_IRQ_LO       8
`define MTC_S_EXCESS_COLLISION_FLAG       4
`define MTC_S_INTTX        7
`define MTC_S_UNDER        8
`define MTC_S_DEFER        9
`define MTC_S_NCARR        10
`define MTC_S_LATE         12
`define MTC_S_PAR          13
`define MTC_S_COMP         14
`define MTC_S_HALTED       15
`define MTC_MAX_COLL       16
`define MTC_LATE_BITS      512
`define MTC_MAXDEF_100_NS  327680
`define MTC_MAXDEF_10_NS   3276800
`define MTC_CLK_NS         4
`define MTC_MAXDEF_100_CYC (`MTC_MAXDEF_100_NS / `MTC_CLK_NS)
`define MTC_MAXDEF_10_CYC  (`MTC_MAXDEF_10_NS / `MTC_CLK_NS)
`endif

// file: hdl/mtc_pkg.sv
// types of the transmit control block
package mtc_pkg;
	typedef enum logic [3:0] {
		MTC_IDLE  = 4'b0001,
		MTC_DEFER = 4'b0010,
		MTC_SEND  = 4'b0100,
		MTC_STOP  = 4'b1000
	} mtc_state_t;

	// per-packet events from the transmit datapath
	typedef struct packed {
		logic fifo_empty;
		logic parity_err;
		logic collision;
		logic pkt_done;
		logic pkt_ctrl;
	} mtc_tx_ev_t;

	// control bits handed to the datapath
	typedef struct packed {
		logic pad_suppress;
		logic fcs_suppress;
		logic fast_backoff;
		logic sqe_test_mode_enable;
		logic send_control_frame;
	} mtc_cfg_t;
endpackage

// file: hdl/mtc_top.sv
// transmit control, status and gating logic with its apb slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defs.svh"

// Summary of operation
// RL1 - transmit only while enable set; clear stops
// RL2 - halt request stops after current packet
// RL3 - pad suppress stops padding short packets
// RL4 - fcs suppress omits frame check sequence
// RL5 - fast backoff shortens collision backoff
// RL6 - no defer disables defer counter
// RL7 - send pause sends control frame, self-clears
// RL8 - writing zero to send pause ignored
// RL9 - sqe test mode enable bit
// RL10 - underrun interrupt when fifo empties mid-packet
// RL11 - deferral interrupt after max deferral time
// RL12 - no carrier interrupt per whole packet
// RL13 - excessive collision interrupt at sixteen; code sets status bit 4 but irq never sees it
// RL14 - late collision interrupt after 512 bits
// RL15 - fifo parity interrupt
// RL16 - completion interrupt on sent or discarded
// RL17 - events set status flag, enabled raise irq
// RL18 - parity error clears enable if enabled
// RL19 - excess flag and count form one count
// RL20 - software sets all enables for per-packet irq
// RL21 - sixteen collisions abort packet, set flag
// RL22 - halted flag on enable clear or stop
// RL23 - upper bits read zero, all reset zero
module mtc_top #(
	parameter int MAXDEF_100 = `MTC_MAXDEF_100_CYC,
	parameter int MAXDEF_10  = `MTC_MAXDEF_10_CYC
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [15:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// line side and datapath
	input  wire logic              carrier_sense,
	input  wire logic              immediate_stop,
	input  wire logic              speed_10,
	input  wire logic              pkt_ready,
	input  wire mtc_pkg::mtc_tx_ev_t tx_ev,
	input  wire logic              late_window,
	output var  logic              tx_go,
	output var  logic              tx_abort,
	output var  mtc_pkg::mtc_cfg_t cfg,
	output var  logic              irq
);
	initial begin
		if (MAXDEF_100 < 1 || MAXDEF_10 < 1) $error("deferral counts must be positive");
	end

	logic [31:0]         ctrl_q;
	logic [15:0]         stat_q;
	mtc_pkg::mtc_state_t st_q;
	logic [22:0]         defer_q;
	logic [3:0]          coll_q;
	logic                carr_seen_q;
	logic                wr_ctrl;
	logic                wr_stat;
	logic                rd_acc;
	logic [22:0]         defer_lim;
	logic                ev_excess_collision_flag;
	logic                ev_defer;
	logic                ev_ncarr;
	logic                ev_late;
	logic                ev_halt;
	logic [15:0]         set_v;

	// apb decode, zero wait states
	assign wr_ctrl = psel && penable && pwrite && paddr == `MTC_OFF_CTRL;
	assign wr_stat = psel && penable && pwrite && paddr == `MTC_OFF_STAT;
	assign rd_acc  = psel && !penable && !pwrite;
	assign defer_lim = speed_10 ? 23'(MAXDEF_10) : 23'(MAXDEF_100);

	// events derived from the sequencer
	assign ev_excess_collision_flag = st_q == mtc_pkg::MTC_SEND && tx_ev.collision
		&& coll_q == 4'hf; // see RL21
	assign ev_defer = st_q == mtc_pkg::MTC_DEFER && !ctrl_q[`MTC_B_DEFER_COUNTER_DISABLE]
		&& defer_q == defer_lim - 23'h000001; // see RL11
	assign ev_ncarr = st_q == mtc_pkg::MTC_SEND && tx_ev.pkt_done
		&& !carr_seen_q && !carrier_sense; // see RL12
	assign ev_late = st_q == mtc_pkg::MTC_SEND && tx_ev.collision && late_window; // see RL14
	assign ev_halt = st_q == mtc_pkg::MTC_SEND && (!ctrl_q[`MTC_B_TX_ENABLE_BIT] || immediate_stop); // see RL22

	// sticky event vector in status bit order
	always_comb begin
		set_v = 16'h0000;
		set_v[`MTC_S_EXCESS_COLLISION_FLAG] = ev_excess_collision_flag;
		set_v[`MTC_S_UNDER]  = st_q == mtc_pkg::MTC_SEND && tx_ev.fifo_empty; // see RL10
		set_v[`MTC_S_DEFER]  = ev_defer;
		set_v[`MTC_S_NCARR]  = ev_ncarr;
		set_v[`MTC_S_LATE]   = ev_late;
		set_v[`MTC_S_PAR]    = tx_ev.parity_err; // see RL18
		set_v[`MTC_S_COMP]   = st_q == mtc_pkg::MTC_SEND
			&& (tx_ev.pkt_done || ev_excess_collision_flag || ev_halt); // see RL16
		set_v[`MTC_S_HALTED] = ev_halt;
		set_v[`MTC_S_INTTX]  = |(set_v[14:8] & ctrl_q[14:8]); // see RL17
	end

	// control register: software writes, hardware clears
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= `MTC_CTRL_RESET; // see RL23
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= pwdata & `MTC_CTRL_MASK; // see RL23
				ctrl_q[`MTC_B_SEND_CONTROL_FRAME] <= ctrl_q[`MTC_B_SEND_CONTROL_FRAME] | pwdata[`MTC_B_SEND_CONTROL_FRAME]; // see RL8
			end
			if (st_q == mtc_pkg::MTC_SEND && tx_ev.pkt_done && tx_ev.pkt_ctrl) begin
				ctrl_q[`MTC_B_SEND_CONTROL_FRAME] <= 1'b0; // see RL7
			end
			if (tx_ev.parity_err && ctrl_q[`MTC_B_IRQ_LO + 5]) begin
				ctrl_q[`MTC_B_TX_ENABLE_BIT] <= 1'b0; // see RL18
			end
		end
	end

	// status register: write one to clear, set wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stat_q <= 16'h0000;
		end else begin
			stat_q <= ((stat_q & ~(wr_stat ? pwdata[15:0] : 16'h0000)) | set_v) & 16'hfff0; // see RL17
		end
	end

	// transmit sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= mtc_pkg::MTC_IDLE;
		end else begin
			case (st_q)
				mtc_pkg::MTC_IDLE: begin
					if (ctrl_q[`MTC_B_TX_ENABLE_BIT] && !ctrl_q[`MTC_B_HALTREQ] && !immediate_stop
						&& (pkt_ready || ctrl_q[`MTC_B_SEND_CONTROL_FRAME])) begin // see RL2
						st_q <= mtc_pkg::MTC_DEFER;
					end
				end
				mtc_pkg::MTC_DEFER: begin
					if (!ctrl_q[`MTC_B_TX_ENABLE_BIT] || immediate_stop) begin
						st_q <= mtc_pkg::MTC_IDLE; // see RL1
					end else if (!carrier_sense || ctrl_q[`MTC_B_DEFER_COUNTER_DISABLE]) begin
						st_q <= mtc_pkg::MTC_SEND; // see RL6
					end
				end
				mtc_pkg::MTC_SEND: begin
					if (ev_halt) begin
						st_q <= mtc_pkg::MTC_STOP; // see RL1
					end else if (tx_ev.pkt_done || ev_excess_collision_flag) begin
						st_q <= mtc_pkg::MTC_IDLE; // see RL2
					end
				end
				mtc_pkg::MTC_STOP: begin
					st_q <= mtc_pkg::MTC_IDLE;
				end
				default: begin
					st_q <= mtc_pkg::MTC_IDLE;
				end
			endcase
		end
	end

	// defer counter runs while carrier holds off the send
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			defer_q <= 23'h000000;
		end else if (st_q == mtc_pkg::MTC_DEFER && !ctrl_q[`MTC_B_DEFER_COUNTER_DISABLE]) begin
			defer_q <= (defer_q == defer_lim - 23'h000001) ? 23'h000000 : defer_q + 23'h000001; // see RL6
		end else begin
			defer_q <= 23'h000000;
		end
	end

	// collision count and carrier seen for the packet in flight
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			coll_q      <= 4'h0;
			carr_seen_q <= 1'b0;
		end else if (st_q != mtc_pkg::MTC_SEND) begin
			coll_q      <= 4'h0;
			carr_seen_q <= 1'b0;
		end else begin
			if (tx_ev.collision) begin
				coll_q <= coll_q + 4'h1; // see RL13
			end
			if (carrier_sense) begin
				carr_seen_q <= 1'b1;
			end
		end
	end

	// count of the finished packet goes to the low status bits
	logic [3:0] cnt_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 4'h0;
		end else if (ev_excess_collision_flag) begin
			cnt_q <= 4'h0; // see RL19
		end else if (st_q == mtc_pkg::MTC_SEND && tx_ev.pkt_done) begin
			cnt_q <= coll_q;
		end
	end

	// apb read data and answer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && paddr != `MTC_OFF_CTRL && paddr != `MTC_OFF_STAT;
			if (rd_acc) begin
				case (paddr)
					`MTC_OFF_CTRL: prdata <= ctrl_q;
					`MTC_OFF_STAT: prdata <= {16'h0000, stat_q[15:5],
						stat_q[`MTC_S_EXCESS_COLLISION_FLAG] ? 1'b1 : 1'b0,
						stat_q[`MTC_S_EXCESS_COLLISION_FLAG] ? 4'h0 : cnt_q}; // see RL19
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// datapath controls, registered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_go    <= 1'b0;
			tx_abort <= 1'b0;
			cfg      <= '0;
			irq      <= 1'b0;
		end else begin
			tx_go    <= st_q == mtc_pkg::MTC_DEFER && ctrl_q[`MTC_B_TX_ENABLE_BIT] && !immediate_stop
				&& (!carrier_sense || ctrl_q[`MTC_B_DEFER_COUNTER_DISABLE]); // see RL1
			tx_abort <= ev_halt || ev_excess_collision_flag; // see RL21
			cfg.pad_suppress         <= ctrl_q[`MTC_B_PAD_SUPPRESS]; // see RL3
			cfg.fcs_suppress         <= ctrl_q[`MTC_B_NOFCS]; // see RL4
			cfg.fast_backoff         <= ctrl_q[`MTC_B_FAST_BACKOFF]; // see RL5
			cfg.sqe_test_mode_enable <= ctrl_q[`MTC_B_SQE]; // see RL9
			cfg.send_control_frame   <= ctrl_q[`MTC_B_SEND_CONTROL_FRAME]; // see RL7
			irq <= |(stat_q[14:8] & ctrl_q[14:8]); // see RL15
		end
	end

	// tx enable cleared while sending ends the packet next cycle
	a_enable_stop: assert property (@(posedge clk) disable iff (reset) // see RL1
		(st_q == mtc_pkg::MTC_SEND && !ctrl_q[`MTC_B_TX_ENABLE_BIT]) |=> st_q == mtc_pkg::MTC_STOP && tx_abort)
		else $error("send did not stop on enable clear");
	a_pause_zero: assert property (@(posedge clk) disable iff (reset) // see RL8
		(ctrl_q[`MTC_B_SEND_CONTROL_FRAME] && wr_ctrl && !tx_ev.pkt_done) |=> ctrl_q[`MTC_B_SEND_CONTROL_FRAME])
		else $error("send pause cleared by software");
	a_pause_clear: assert property (@(posedge clk) disable iff (reset) // see RL7
		(st_q == mtc_pkg::MTC_SEND && tx_ev.pkt_done && tx_ev.pkt_ctrl && !wr_ctrl)
		|=> !ctrl_q[`MTC_B_SEND_CONTROL_FRAME])
		else $error("send pause not cleared after frame");
	a_parity_off: assert property (@(posedge clk) disable iff (reset) // see RL18
		(tx_ev.parity_err && ctrl_q[13]) |=> !ctrl_q[`MTC_B_TX_ENABLE_BIT] && stat_q[`MTC_S_PAR])
		else $error("parity error left enable set");
	a_excess_collision_flag_flag: assert property (@(posedge clk) disable iff (reset) // see RL21
		ev_excess_collision_flag |=> stat_q[`MTC_S_EXCESS_COLLISION_FLAG] && st_q == mtc_pkg::MTC_IDLE)
		else $error("excess collision not flagged");
	a_halt_wait: assert property (@(posedge clk) disable iff (reset) // see RL2
		(st_q == mtc_pkg::MTC_IDLE && ctrl_q[`MTC_B_HALTREQ]) |=> st_q != mtc_pkg::MTC_DEFER)
		else $error("new packet started under halt request");
	a_irq_follow: assert property (@(posedge clk) disable iff (reset) // see RL17
		(set_v[`MTC_S_COMP] && ctrl_q[14]) |=> ##1 irq)
		else $error("completion did not raise irq");
	a_upper_zero: assert property (@(posedge clk) disable iff (reset) // see RL23
		ctrl_q[31:15] == 17'h00000)
		else $error("reserved control bits set");

	// datapath controls follow the control register one cycle later
	a_cfg_pad_suppress: assert property (@(posedge clk) disable iff (reset) // see RL3
		1'b1 |=> cfg.pad_suppress == $past(ctrl_q[`MTC_B_PAD_SUPPRESS]))
		else $error("pad suppress not passed on");
	a_cfg_nofcs: assert property (@(posedge clk) disable iff (reset) // see RL4
		1'b1 |=> cfg.fcs_suppress == $past(ctrl_q[`MTC_B_NOFCS]))
		else $error("fcs suppress not passed on");
	a_cfg_fast_backoff: assert property (@(posedge clk) disable iff (reset) // see RL5
		1'b1 |=> cfg.fast_backoff == $past(ctrl_q[`MTC_B_FAST_BACKOFF]))
		else $error("fast backoff not passed on");
	a_cfg_sqe: assert property (@(posedge clk) disable iff (reset) // see RL9
		1'b1 |=> cfg.sqe_test_mode_enable == $past(ctrl_q[`MTC_B_SQE]))
		else $error("sqe test mode not passed on");
	a_cfg_pause: assert property (@(posedge clk) disable iff (reset) // see RL7
		1'b1 |=> cfg.send_control_frame == $past(ctrl_q[`MTC_B_SEND_CONTROL_FRAME]))
		else $error("send control frame not passed on");

	// no defer keeps the defer counter at rest
	a_defer_counter_disable_rest: assert property (@(posedge clk) disable iff (reset) // see RL6
		ctrl_q[`MTC_B_DEFER_COUNTER_DISABLE] |=> defer_q == 23'h000000)
		else $error("defer counter ran with no defer set");

	// every event lands in its sticky status flag
	a_under_flag: assert property (@(posedge clk) disable iff (reset) // see RL10
		set_v[`MTC_S_UNDER] |=> stat_q[`MTC_S_UNDER])
		else $error("underrun not flagged");
	a_defer_flag: assert property (@(posedge clk) disable iff (reset) // see RL11
		ev_defer |=> stat_q[`MTC_S_DEFER])
		else $error("deferral not flagged");
	a_ncarr_flag: assert property (@(posedge clk) disable iff (reset) // see RL12
		ev_ncarr |=> stat_q[`MTC_S_NCARR])
		else $error("no carrier not flagged");
	a_late_flag: assert property (@(posedge clk) disable iff (reset) // see RL14
		ev_late |=> stat_q[`MTC_S_LATE])
		else $error("late collision not flagged");
	a_comp_flag: assert property (@(posedge clk) disable iff (reset) // see RL16
		(st_q == mtc_pkg::MTC_SEND && tx_ev.pkt_done) |=> stat_q[`MTC_S_COMP])
		else $error("completion not flagged");
	a_halt_flag: assert property (@(posedge clk) disable iff (reset) // see RL22
		ev_halt |=> stat_q[`MTC_S_HALTED] && tx_abort)
		else $error("halt not flagged");

	// sixteen collisions abort the packet at once
	a_excess_collision_flag_abort: assert property (@(posedge clk) disable iff (reset) // see RL21
		ev_excess_collision_flag |=> tx_abort)
		else $error("excess collision did not abort");

	// enabled flags raise the interrupt line
	a_irq_level: assert property (@(posedge clk) disable iff (reset) // see RL17
		(|(stat_q[14:8] & ctrl_q[14:8])) |=> irq)
		else $error("enabled flag did not raise irq");
	a_par_irq: assert property (@(posedge clk) disable iff (reset) // see RL15
		(stat_q[`MTC_S_PAR] && ctrl_q[13]) |=> irq)
		else $error("parity flag did not raise irq");

	// status read keeps flag and count exclusive
	a_count_excl: assert property (@(posedge clk) disable iff (reset) // see RL19
		(rd_acc && paddr == `MTC_OFF_STAT) |=> !(prdata[4] && prdata[3:0] != 4'h0))
		else $error("excess flag read with non-zero count");
endmodule
`default_nettype wire

// file: dv/mtc_phy_model.sv
// far-side model: datapath and line events for the transmit control block
`timescale 1ns/1ps
`default_nettype none
module mtc_phy_model (
	// clock, reset and bench commands
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                start,
	input  wire logic [2:0]          mode,
	// block side
	input  wire logic                tx_go,
	output var  logic                pkt_ready,
	output var  logic                carrier_sense,
	output var  logic                late_window,
	output var  mtc_pkg::mtc_tx_ev_t tx_ev
);
	logic       busy_q;
	logic [5:0] cnt_q;
	// a packet is offered until the block starts it, then stays 40 cycles on the line
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pkt_ready <= 1'b0;
			busy_q    <= 1'b0;
			cnt_q     <= 6'h00;
		end else if (start) begin
			pkt_ready <= 1'b1;
		end else if (tx_go && pkt_ready) begin
			pkt_ready <= 1'b0;
			busy_q    <= 1'b1;
			cnt_q     <= 6'h00;
		end else if (busy_q) begin
			cnt_q  <= cnt_q + 6'h01;
			busy_q <= cnt_q != 6'h27;
		end
	end
	// mode 0 underrun then done, 1 control frame, 2 parity fault, 3 sixteen collisions, 4 never ends
	always_comb begin
		tx_ev            = '0;
		tx_ev.fifo_empty = busy_q && cnt_q == 6'h04 && mode == 3'h0;
		tx_ev.pkt_done   = busy_q && cnt_q == 6'h08 && mode < 3'h2;
		tx_ev.pkt_ctrl   = tx_ev.pkt_done && mode == 3'h1;
		tx_ev.parity_err = busy_q && cnt_q == 6'h08 && mode == 3'h2;
		tx_ev.collision  = busy_q && mode == 3'h3 && cnt_q >= 6'h08 && !cnt_q[0];
	end
	// carrier seen for the whole packet, late window after 20 cycles
	assign carrier_sense = busy_q;
	assign late_window   = busy_q && cnt_q >= 6'h14;
endmodule
`default_nettype wire

// file: dv/mac_transmit_control_tb.sv
// self-checking bench of the transmit control block
`timescale 1ns/1ps
`default_nettype none
module mac_transmit_control_tb;
	localparam logic [15:0] ctrl_a = 16'ha008;
	localparam logic [15:0] stat_a = 16'ha00c;
	logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, cs, rdy, late, tx_go, tx_abort, irq, start = 1'b0;
	logic [2:0] mode = 3'h0;
	logic abort_seen = 1'b0;
	mtc_pkg::mtc_tx_ev_t ev;
	mtc_pkg::mtc_cfg_t cfg;
	int errors = 0, check_count = 0, cyc = 0;
	always #2 clk = ~clk;
	mtc_top #(.MAXDEF_100(20), .MAXDEF_10(40)) i_mtc_top (.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .carrier_sense(cs),
		.immediate_stop(1'b0), .speed_10(1'b0), .pkt_ready(rdy), .tx_ev(ev),
		.late_window(late), .tx_go(tx_go), .tx_abort(tx_abort), .cfg(cfg), .irq(irq));
	mtc_phy_model i_mtc_phy_model (.clk(clk), .reset(reset), .start(start), .mode(mode),
		.tx_go(tx_go), .pkt_ready(rdy), .carrier_sense(cs), .late_window(late), .tx_ev(ev));
	// cycle ceiling and abort watch
	always @(posedge clk) begin
		cyc++;
		if (tx_abort === 1'b1) abort_seen <= 1'b1;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	// offer a packet, optionally wait until the line is quiet again
	task automatic pkt(input logic [2:0] m, input logic wait_idle);
		@(posedge clk);
		mode  <= m;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (2) @(posedge clk);
		while (wait_idle && (rdy !== 1'b0 || cs !== 1'b0)) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask
	task automatic t_regs;
		rdchk(ctrl_a, 32'hffffffff, 32'h0);
		rdchk(stat_a, 32'hffffffff, 32'h0);
		apb(1'b1, ctrl_a, 32'hfffffffe);
		rdchk(ctrl_a, 32'hffffffff, 32'h7ffe);
		chk({27'h0, cfg}, 32'h1f);
		apb(1'b1, ctrl_a, 32'h0);
		rdchk(ctrl_a, 32'hffffffff, 32'h40);
		apb(1'b0, 16'ha100, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		$display("registers done");
	endtask
	task automatic t_ctrl_frame;
		pkt(3'h1, 1'b0);
		apb(1'b1, ctrl_a, 32'h41);
		repeat (60) @(posedge clk);
		rdchk(ctrl_a, 32'hffffffff, 32'h1);
		$display("control frame done");
	endtask
	task automatic t_comp;
		apb(1'b1, stat_a, 32'hffff);
		apb(1'b1, ctrl_a, 32'h7f01);
		pkt(3'h0, 1'b1);
		rdchk(stat_a, 32'h4000, 32'h4000);
		rdchk(stat_a, 32'h0100, 32'h0100);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, stat_a, 32'hffff);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		$display("completion done");
	endtask
	task automatic t_coll;
		pkt(3'h3, 1'b1);
		rdchk(stat_a, 32'h1f, 32'h10);
		rdchk(stat_a, 32'h1000, 32'h1000);
		chk({30'h0, irq, abort_seen}, 32'h3);
		$display("collisions done");
	endtask
	task automatic t_parity;
		apb(1'b1, stat_a, 32'hffff);
		apb(1'b1, ctrl_a, 32'h2001);
		pkt(3'h2, 1'b1);
		rdchk(stat_a, 32'h2000, 32'h2000);
		rdchk(ctrl_a, 32'hffffffff, 32'h2000);
		chk({31'h0, irq}, 32'h1);
		$display("parity done");
	endtask
	task automatic t_stop;
		apb(1'b1, stat_a, 32'hffff);
		apb(1'b1, ctrl_a, 32'h1);
		pkt(3'h4, 1'b0);
		apb(1'b1, ctrl_a, 32'h0);
		chk({31'h0, tx_go}, 32'h0);
		rdchk(stat_a, 32'h8000, 32'h8000);
		repeat (50) @(posedge clk);
		$display("stop done");
	endtask
	task automatic t_halt_req;
		apb(1'b1, stat_a, 32'hffff);
		apb(1'b1, ctrl_a, 32'h1);
		pkt(3'h0, 1'b0);
		apb(1'b1, ctrl_a, 32'h3);
		pkt(3'h0, 1'b0);
		repeat (50) @(posedge clk);
		rdchk(stat_a, 32'h4000, 32'h4000);
		chk({31'h0, rdy}, 32'h1);
		rdchk(stat_a, 32'h8000, 32'h0);
		$display("halt request done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		chk({31'h0, irq}, 32'h0);
		t_regs();
		t_ctrl_frame();
		t_comp();
		t_coll();
		t_parity();
		t_stop();
		t_halt_req();
		conclude();
	end
endmodule
`default_nettype wire
